// *** src/fts_pkg.sv ***
// Purpose: shared constants of the fan tach monitor
// Assumes: 8-bit indexed register port, 250 MHz clock
// Notes:   pwm prescale values are rounded to nearest step
package fts_pkg;
   // ==========================================================
   // clocking
   localparam int unsigned CLK_HZ  = 250_000_000;
   localparam int unsigned REF_HZ  = 90_000;
   localparam int unsigned OSC_HZ  = 14_318_000;
   localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;
   localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
   // ==========================================================
   // register offsets (fan n at +2n for readings/minimums)
   localparam logic [7:0] OFF_READ_LO = 8'h28;
   localparam logic [7:0] OFF_STATUS  = 8'h42;
   localparam logic [7:0] OFF_MIN_LO  = 8'h54;
   localparam logic [7:0] OFF_FREQ    = 8'h5f;
   localparam logic [7:0] OFF_CONFIG  = 8'h7f;
   localparam logic [7:0] OFF_ENABLE  = 8'h80;
   localparam logic [7:0] OFF_LINK    = 8'h81;
   localparam logic [7:0] OFF_OPTION  = 8'h90;
   localparam logic [7:0] OFF_MODE    = 8'ha0;
   // ==========================================================
   // reset values
   localparam logic [3:0]  RST_ENABLE = 4'he;
   localparam logic [7:0]  RST_LINK   = 8'h24;
   localparam logic [7:0]  RST_OPTION = 8'h04;
   localparam logic [7:0]  RST_MODE   = 8'h00;
   localparam logic [3:0]  RST_FREQ   = 4'hb;
   localparam logic        RST_SPINUP_REDUCE_ENABLE  = 1'b1;
   localparam logic [15:0] RST_MIN    = 16'hffff;
   // ==========================================================
   // field positions
   localparam int unsigned ENA_GROUP = 0;
   localparam int unsigned ENA_FAN   = 1;
   localparam int unsigned STS_FAN   = 2;
   localparam int unsigned CFG_SPINUP_REDUCE_ENABLE = 4;
   localparam int unsigned OPT_SLOW  = 0;
   localparam int unsigned OPT_EDGES = 1;
   localparam int unsigned OPT_MODE2 = 3;
   localparam int unsigned OPT_GUARD = 4;
   // ==========================================================
   // codes
   localparam logic [15:0] CNT_STALL    = 16'hffff;
   localparam logic [15:0] CNT_SLOW     = 16'hfffe;
   localparam logic [1:0]  MODE_LOCK_HI = 2'b01;
   localparam logic [1:0]  MODE_LOCK_LO = 2'b10;
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_GUARD = 3'b010,
      S_COUNT = 3'b100
   } fts_state_t;
   // ==========================================================
   // edges per measurement: 2, 3, 5 or 9
   function automatic logic [3:0] edgeTarget(input logic [1:0] s);
      case (s)
         2'd0:    return 4'd2;
         2'd1:    return 4'd3;
         2'd2:    return 4'd5;
         default: return 4'd9;
      endcase
   endfunction
   // guard time in 90 kHz clocks
   function automatic logic [5:0] guardLimit(input logic [1:0] s);
      case (s)
         2'd0:    return 6'd8;
         2'd1:    return 6'd16;
         2'd2:    return 6'd32;
         default: return 6'd63;
      endcase
   endfunction
   // 14.318 MHz ticks per pwm step (256 steps a period)
   function automatic logic [12:0] prescale(input logic [3:0] f);
      case (f)
         4'h0:    return 13'd5084; // 11.0 Hz
         4'h1:    return 13'd3831; // 14.6 Hz
         4'h2:    return 13'd2554; // 21.9 Hz
         4'h3:    return 13'd1909; // 29.3 Hz
         4'h4:    return 13'd1589; // 35.2 Hz
         4'h5:    return 13'd1271; // 44.0 Hz
         4'h6:    return 13'd954;  // 58.6 Hz
         4'h7:    return 13'd638;  // 87.7 Hz
         4'h8:    return 13'd4;    // 15 kHz
         4'h9:    return 13'd3;    // 20 kHz
         4'ha:    return 13'd2;    // 30 kHz, coarse
         default: return 13'd2;    // 25 kHz
      endcase
   endfunction
endpackage

// *** src/fts_monitor.sv ***
// Purpose: three-channel fan tach supervision and pwm timebase
// Assumes: fan inputs synchronous to clk; duty from auto control
// Notes:   registers reached over a byte-wide indexed port
`timescale 1ns/1ps
// Operation
// - no edge in window: stall, reading FFFFh
// - slow fan with option set loads FFFEh
// - saturation before last edge counts as slow
// - option clear: slow fan loads FFFFh
// - mode 1 latches count on last edge
// - mode 2 latches on last edge during on-time
// - last edge ends detection, resets state machine
// - reading above minimum sets fail status bit
// - stall holds FFFFh, next valid count latches
// - status needs reading above minimum and enable
// - minimum FFFFh never sets status from a reading
// - fan enables reset on, group enable off
// - locked-rotor level sets status, may interrupt
// - two-bit mode field per fan decoded
// - link register picks pwm per tach
// - spin-up hold released when linked fan normal
// - pwm gates mode 2, blocks mode 1 events when off
// - all pwm rates from 14.318 MHz
// - four-bit select, reset selects 25 kHz
// - full duty gives 255/256, never constant
// - count 90 kHz pulses, measurement ends at FFFEh
// - edges per measurement 2, 3, 5, 9
// - mode 2 waits pwm high plus guard
// - low byte read freezes high byte
module fts_monitor #(
   parameter int unsigned REF_DIV = fts_pkg::REF_DIV,
   parameter int unsigned OSC_DIV = fts_pkg::OSC_DIV
) (
   input  wire logic            clk,
   input  wire logic            reset_n,
   input  wire logic [7:0]      regAddr,
   input  wire logic            regWrEn,
   input  wire logic            regRdEn,
   input  wire logic [7:0]      regWrData,
   output logic      [7:0]      regRdData,
   input  wire logic [2:0]      fanSpeedInput,
   input  wire logic [2:0][7:0] autoDuty,
   input  wire logic [2:0]      spinupHold,
   output logic      [2:0]      fanDriveOutput,
   output logic                 monitorInterruptPin_n
);
   if (REF_DIV < 2 || REF_DIV > 4096 || OSC_DIV < 2 || OSC_DIV > 32)
   begin : g_bad_div
      $error("divider out of range");
   end

   // ==========================================================
   // state
   logic [11:0]        refDivCnt;
   logic               refTick;
   logic [4:0]         oscDivCnt;
   logic               oscTick;
   logic [12:0]        prescCnt;
   logic [7:0]         pwmCnt;
   logic [3:0]         freqSel;
   logic               spinupReduceEnable;
   logic [3:0]         enableReg;
   logic [7:0]         linkReg;
   logic [7:0]         modeReg;
   logic [7:0]         option   [3];
   logic [15:0]        minimum  [3];
   logic [15:0]        reading  [3];
   logic [15:0]        cnt      [3];
   logic [3:0]         edges    [3];
   logic [5:0]         guardCnt [3];
   fts_pkg::fts_state_t state   [3];
   logic [15:0]        resVal   [3];
   logic [2:0]         resStb;
   logic [2:0]         resGate;
   logic [2:0]         fanOk;
   logic [2:0]         fanFail;
   logic [2:0]         tachPrev;
   logic [2:0]         pwmPrev;
   logic [2:0]         hiFrozen;
   logic [7:0]         hiShadow [3];
   // combinational
   logic [2:0]         tachEdge;
   logic [2:0]         pwmOnL;
   logic [2:0]         locked;
   logic [2:0]         lockActive;
   logic [2:0]         finNow;
   logic [15:0]        finVal   [3];
   logic [2:0]         failSet;
   logic [2:0]         holdEff;
   logic [2:0]         okToPwm;
   logic [7:0]         rdMux;

   // ==========================================================
   // timebases: 90 kHz tach clock and 14.318 MHz pwm clock
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         refDivCnt <= '0;
         refTick   <= 1'b0;
      end else if (refDivCnt == 12'(REF_DIV - 1)) begin
         refDivCnt <= '0;
         refTick   <= 1'b1;
      end else begin
         refDivCnt <= refDivCnt + 12'd1;
         refTick   <= 1'b0;
      end
   end

   // integer divide of the system clock, so rates are approximate
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         oscDivCnt <= '0;
         oscTick   <= 1'b0;
      end else if (oscDivCnt == 5'(OSC_DIV - 1)) begin
         oscDivCnt <= '0;
         oscTick   <= 1'b1;
      end else begin
         oscDivCnt <= oscDivCnt + 5'd1;
         oscTick   <= 1'b0;
      end
   end

   // one shared 8-bit duty counter stepped by the prescaler
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prescCnt <= '0;
         pwmCnt   <= '0;
      end else if (oscTick) begin
         if (prescCnt >= fts_pkg::prescale(freqSel) - 13'd1) begin
            prescCnt <= '0;
            pwmCnt   <= pwmCnt + 8'd1;
         end else begin
            prescCnt <= prescCnt + 13'd1;
         end
      end
   end

   // ==========================================================
   // pwm outputs and spin-up reduction
   always_comb begin
      okToPwm = '0;
      for (int i = 0; i < 3; i++) begin
         okToPwm[linkIdx(i)] = okToPwm[linkIdx(i)] | fanOk[i];
      end
      holdEff = spinupHold & ~({3{spinupReduceEnable}} & okToPwm);
   end

   // compare against 0..255: duty ff stays low one step in 256
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fanDriveOutput <= '0;
      end else begin
         for (int j = 0; j < 3; j++) begin
            fanDriveOutput[j] <= holdEff[j] | (pwmCnt < autoDuty[j]);
         end
      end
   end

   function automatic logic [1:0] linkIdx(input int i);
      logic [1:0] s;
      s = linkReg[2*i +: 2];
      return (s == 2'd3) ? 2'd2 : s;
   endfunction

   // ==========================================================
   // per-channel input decode
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         tachEdge[i]   = fanSpeedInput[i] ^ tachPrev[i];
         pwmOnL[i]     = fanDriveOutput[linkIdx(i)];
         locked[i]     = modeReg[7-2*i -: 2] == fts_pkg::MODE_LOCK_HI ||
                         modeReg[7-2*i -: 2] == fts_pkg::MODE_LOCK_LO;
         lockActive[i] = (modeReg[7-2*i -: 2] == fts_pkg::MODE_LOCK_HI &&
                          fanSpeedInput[i]) ||
                         (modeReg[7-2*i -: 2] == fts_pkg::MODE_LOCK_LO &&
                          !fanSpeedInput[i]);
      end
   end

   // end-of-measurement decision for each channel
   always_comb begin
      logic [15:0] slowV;
      slowV = fts_pkg::CNT_STALL;
      for (int i = 0; i < 3; i++) begin
         slowV = option[i][fts_pkg::OPT_SLOW] ? fts_pkg::CNT_SLOW
                                              : fts_pkg::CNT_STALL;
         finNow[i] = 1'b0;
         finVal[i] = fts_pkg::CNT_STALL;
         if (state[i] == fts_pkg::S_COUNT && !locked[i]) begin
            if (option[i][fts_pkg::OPT_MODE2] && !pwmOnL[i]) begin
               finNow[i] = 1'b1;
               finVal[i] = (edges[i] == 4'd0) ? fts_pkg::CNT_STALL
                                              : slowV;
            end else if (tachEdge[i] && edges[i] == fts_pkg::edgeTarget(
                         option[i][fts_pkg::OPT_EDGES +: 2]) - 4'd1) begin
               finNow[i] = 1'b1;
               finVal[i] = cnt[i];
            end else if (!tachEdge[i] && refTick &&
                         cnt[i] == fts_pkg::CNT_SLOW) begin
               finNow[i] = 1'b1;
               finVal[i] = (edges[i] == 4'd0) ? fts_pkg::CNT_STALL
                                              : slowV;
            end
         end
      end
   end

   // ==========================================================
   // measurement state machines, one per fan
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tachPrev <= '0;
         pwmPrev  <= '0;
         resStb   <= '0;
         resGate  <= '0;
         fanOk    <= '0;
         for (int i = 0; i < 3; i++) begin
            state[i]    <= fts_pkg::S_IDLE;
            cnt[i]      <= '0;
            edges[i]    <= '0;
            guardCnt[i] <= '0;
            reading[i]  <= fts_pkg::CNT_STALL;
            resVal[i]   <= fts_pkg::CNT_STALL;
         end
      end else begin
         tachPrev <= fanSpeedInput;
         pwmPrev  <= pwmOnL;
         resStb   <= finNow;
         for (int i = 0; i < 3; i++) begin
            if (finNow[i]) begin
               reading[i] <= finVal[i];
               resVal[i]  <= finVal[i];
               resGate[i] <= option[i][fts_pkg::OPT_MODE2] | pwmOnL[i];
               fanOk[i]   <= finVal[i] < fts_pkg::CNT_SLOW &&
                             finVal[i] <= minimum[i];
               state[i]   <= fts_pkg::S_IDLE;
            end else if (locked[i]) begin
               state[i] <= fts_pkg::S_IDLE;
            end else begin
               case (state[i])
                  fts_pkg::S_IDLE: begin
                     cnt[i]      <= '0;
                     edges[i]    <= '0;
                     guardCnt[i] <= '0;
                     if (!option[i][fts_pkg::OPT_MODE2])
                        state[i] <= fts_pkg::S_COUNT;
                     else if (pwmOnL[i] && !pwmPrev[i])
                        state[i] <= fts_pkg::S_GUARD;
                  end
                  fts_pkg::S_GUARD: begin
                     if (!pwmOnL[i]) begin
                        state[i] <= fts_pkg::S_IDLE;
                     end else if (refTick) begin
                        guardCnt[i] <= guardCnt[i] + 6'd1;
                        if (guardCnt[i] == fts_pkg::guardLimit(
                            option[i][fts_pkg::OPT_GUARD +: 2]) - 6'd1)
                           state[i] <= fts_pkg::S_COUNT;
                     end
                  end
                  fts_pkg::S_COUNT: begin
                     if (tachEdge[i]) begin
                        edges[i] <= edges[i] + 4'd1;
                        if (edges[i] == 4'd0)
                           cnt[i] <= '0; // first edge starts timing
                     end else if (refTick) begin
                        cnt[i] <= cnt[i] + 16'd1;
                     end
                  end
                  default: state[i] <= fts_pkg::S_IDLE;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // fail status, write-one-to-clear, a new event beats the clear
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         failSet[i] = (resStb[i] && resGate[i] &&
                       resVal[i] > minimum[i] &&
                       minimum[i] != fts_pkg::CNT_STALL &&
                       enableReg[fts_pkg::ENA_FAN+i]) ||
                      (lockActive[i] &&
                       enableReg[fts_pkg::ENA_FAN+i]);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fanFail <= '0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            fanFail[i] <= failSet[i] | (fanFail[i] &
                          ~(regWrEn && regAddr == fts_pkg::OFF_STATUS &&
                            regWrData[fts_pkg::STS_FAN+i]));
         end
      end
   end

   // pin only follows fan events while the group enable is set
   always_ff @(posedge clk) begin
      if (!reset_n)
         monitorInterruptPin_n <= 1'b1;
      else
         monitorInterruptPin_n <= ~(enableReg[fts_pkg::ENA_GROUP] &
                                    (|fanFail));
   end

   // ==========================================================
   // writable registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         enableReg          <= fts_pkg::RST_ENABLE;
         linkReg            <= fts_pkg::RST_LINK;
         modeReg            <= fts_pkg::RST_MODE;
         freqSel            <= fts_pkg::RST_FREQ;
         spinupReduceEnable <= fts_pkg::RST_SPINUP_REDUCE_ENABLE;
         for (int i = 0; i < 3; i++) begin
            option[i]  <= fts_pkg::RST_OPTION;
            minimum[i] <= fts_pkg::RST_MIN;
         end
      end else if (regWrEn) begin
         if (regAddr == fts_pkg::OFF_ENABLE)
            enableReg <= regWrData[3:0];
         if (regAddr == fts_pkg::OFF_LINK)
            linkReg <= regWrData;
         if (regAddr == fts_pkg::OFF_MODE)
            modeReg <= regWrData;
         if (regAddr == fts_pkg::OFF_FREQ)
            freqSel <= regWrData[3:0];
         if (regAddr == fts_pkg::OFF_CONFIG)
            spinupReduceEnable <= regWrData[fts_pkg::CFG_SPINUP_REDUCE_ENABLE];
         for (int i = 0; i < 3; i++) begin
            if (regAddr == fts_pkg::OFF_OPTION + 8'(i))
               option[i] <= regWrData;
            if (regAddr == fts_pkg::OFF_MIN_LO + 8'(2*i))
               minimum[i][7:0] <= regWrData;
            if (regAddr == fts_pkg::OFF_MIN_LO + 8'(2*i+1))
               minimum[i][15:8] <= regWrData;
         end
      end
   end

   // ==========================================================
   // read path; unmapped indices read zero
   always_comb begin
      rdMux = 8'h00;
      if (regAddr == fts_pkg::OFF_STATUS)
         rdMux[fts_pkg::STS_FAN +: 3] = fanFail;
      if (regAddr == fts_pkg::OFF_ENABLE)
         rdMux = {4'h0, enableReg};
      if (regAddr == fts_pkg::OFF_LINK)
         rdMux = linkReg;
      if (regAddr == fts_pkg::OFF_MODE)
         rdMux = modeReg;
      if (regAddr == fts_pkg::OFF_FREQ)
         rdMux = {4'h0, freqSel};
      if (regAddr == fts_pkg::OFF_CONFIG)
         rdMux[fts_pkg::CFG_SPINUP_REDUCE_ENABLE] = spinupReduceEnable;
      for (int i = 0; i < 3; i++) begin
         if (regAddr == fts_pkg::OFF_OPTION + 8'(i))
            rdMux = option[i];
         if (regAddr == fts_pkg::OFF_MIN_LO + 8'(2*i))
            rdMux = minimum[i][7:0];
         if (regAddr == fts_pkg::OFF_MIN_LO + 8'(2*i+1))
            rdMux = minimum[i][15:8];
         if (regAddr == fts_pkg::OFF_READ_LO + 8'(2*i))
            rdMux = reading[i][7:0];
         if (regAddr == fts_pkg::OFF_READ_LO + 8'(2*i+1))
            rdMux = hiFrozen[i] ? hiShadow[i] : reading[i][15:8];
      end
   end

   // low byte read snapshots the high byte so the pair is coherent
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
         hiFrozen  <= '0;
         for (int i = 0; i < 3; i++)
            hiShadow[i] <= 8'h00;
      end else if (regRdEn) begin
         regRdData <= rdMux;
         for (int i = 0; i < 3; i++) begin
            if (regAddr == fts_pkg::OFF_READ_LO + 8'(2*i)) begin
               hiFrozen[i] <= 1'b1;
               hiShadow[i] <= reading[i][15:8];
            end else if (regAddr == fts_pkg::OFF_READ_LO + 8'(2*i+1)) begin
               hiFrozen[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // checks on channel 0 and the interrupt pin
   a_stall_reading: assert property (@(posedge clk) disable iff (!reset_n)
      (finNow[0] && edges[0] == 4'd0) |=> reading[0] == 16'hffff)
      else $error("stall did not load ffff");
   a_slow_code: assert property (@(posedge clk) disable iff (!reset_n)
      (finNow[0] && edges[0] != 4'd0 && !tachEdge[0] &&
       option[0][0]) |=> reading[0] == 16'hfffe)
      else $error("slow fan did not load fffe");
   a_slow_merged: assert property (@(posedge clk) disable iff (!reset_n)
      (finNow[0] && !tachEdge[0] && !option[0][0])
      |=> reading[0] == 16'hffff)
      else $error("slow fan without option not ffff");
   a_count_latch: assert property (@(posedge clk) disable iff (!reset_n)
      (finNow[0] && tachEdge[0] &&
       !(option[0][fts_pkg::OPT_MODE2] && !pwmOnL[0]))
      |=> reading[0] == $past(cnt[0]) &&
          state[0] == fts_pkg::S_IDLE)
      else $error("count not latched on last edge");
   a_fail_set: assert property (@(posedge clk) disable iff (!reset_n)
      (resStb[0] && resGate[0] && resVal[0] > minimum[0] &&
       minimum[0] != 16'hffff && enableReg[1]) |=> fanFail[0])
      else $error("fail bit not set");
   a_min_block: assert property (@(posedge clk) disable iff (!reset_n)
      (minimum[0] == 16'hffff && !locked[0] && !fanFail[0])
      |=> !fanFail[0])
      else $error("fail bit set with minimum ffff");
   a_group_gate: assert property (@(posedge clk) disable iff (!reset_n)
      !enableReg[0] |=> monitorInterruptPin_n)
      else $error("pin active with group disabled");
   a_lock_level: assert property (@(posedge clk) disable iff (!reset_n)
      (lockActive[0] && enableReg[1]) |=> fanFail[0] ##1 fanFail[0]
      or !(lockActive[0] && enableReg[1]))
      else $error("locked rotor not flagged");
   a_full_duty: assert property (@(posedge clk) disable iff (!reset_n)
      (autoDuty[0] == 8'hff && pwmCnt == 8'hff && !holdEff[0])
      |=> !fanDriveOutput[0])
      else $error("full duty drove constant high");
endmodule // fts_monitor

// *** sim/fts_fan_model.sv ***
// Purpose: behavioural fan whose tach toggles at a set half period
// Assumes: one toggle per halfPeriod clocks while run is high
// Notes:   a stopped fan holds lvl, which also acts as locked-rotor pin
`timescale 1ns/1ps
module fts_fan_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic [15:0] halfPeriod,
   input  wire logic        lvl,
   output logic             tach
);
   logic [15:0] cnt;
   // ==========================================================
   // tach edges, each toggle is one counted edge
   always_ff @(posedge clk) begin
      if (!run) begin
         cnt  <= 16'h0000;
         tach <= lvl; // a stall leaves the pin at a level
      end else if (cnt >= halfPeriod - 16'h0001) begin
         cnt  <= 16'h0000;
         tach <= ~tach;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule // fts_fan_model

// *** sim/tb.sv ***
// Purpose: self-checking bench for the fan tach monitor
// Assumes: shortened reference and oscillator dividers
// Notes:   mode 2 uses a fast pwm rate only to keep the run short
`timescale 1ns/1ps
module tb;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   logic [7:0]      regAddr = 8'h00;
   logic            regWrEn = 1'b0;
   logic            regRdEn = 1'b0;
   logic [7:0]      regWrData = 8'h00;
   logic [7:0]      regRdData;
   wire  [2:0]      fanSpeedInput;
   logic [2:0][7:0] autoDuty = {8'hff, 8'hff, 8'hff};
   logic [2:0]      spinupHold = 3'b000;
   logic [2:0]      fanDriveOutput;
   logic            monitorInterruptPin_n;
   logic [2:0]      run = 3'b000;
   logic [2:0]      lvl = 3'b000;
   logic [15:0]     hp = 16'h0028;
   logic [15:0]     rdg;
   logic [7:0]      b;
   logic [1:0]      lo;
   int              err_count = 0;
   int              num_checks = 0;
   // ==========================================================
   // clock, design and fans
   always #2 clk = ~clk;
   fts_monitor #(.REF_DIV(4), .OSC_DIV(2)) fts_monitor_i (
      .clk(clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
      .regRdData(regRdData), .fanSpeedInput(fanSpeedInput),
      .autoDuty(autoDuty), .spinupHold(spinupHold),
      .fanDriveOutput(fanDriveOutput),
      .monitorInterruptPin_n(monitorInterruptPin_n));
   for (genvar k = 0; k < 3; k++) begin : g_fan
      fts_fan_model fts_fan_model_i (.clk(clk), .run(run[k]),
         .halfPeriod(hp), .lvl(lvl[k]), .tach(fanSpeedInput[k]));
   end
   // ==========================================================
   // register port tasks
   task automatic tally_and_finish();
      if (err_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      @(posedge clk);
      #1 b = regRdData;
   endtask
   // low byte first so the high byte is the frozen snapshot
   task automatic rd16(input logic [7:0] a);
      rd(a);
      rdg[7:0] = b;
      rd(a + 8'h01);
      rdg[15:8] = b;
   endtask
   // bounded poll: equal to exp, or below it when lt is set
   task automatic waitr(input logic [7:0] a, input logic [15:0] exp,
                        input logic lt);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 800 && !hit; i++) begin
         rd16(a);
         hit = lt ? (rdg < exp) : (rdg === exp);
      end
      chk({15'h0000, hit}, 16'h0001);
      if (!hit) tally_and_finish();
   endtask
   // ==========================================================
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h80); chk(b, 8'h0e);
      rd(8'h81); chk(b, 8'h24);
      rd(8'h5f); chk(b, 8'h0b);
      rd(8'h10); chk(b, 8'h00);
      rd16(8'h28); chk(rdg, 16'hffff);
      run[0] <= 1'b1;
      waitr(8'h28, 16'h0100, 1'b1);
      chk({15'h0, rdg >= 16'd38 && rdg <= 16'd42}, 16'h1);
      rd16(8'h2a); chk(rdg, 16'hffff);
      wr(8'h5f, 8'h08);
      autoDuty[0] <= 8'h80;
      wr(8'h90, 8'h0d);
      waitr(8'h28, 16'h0100, 1'b1);
      hp <= 16'd600;
      waitr(8'h28, 16'hfffe, 1'b0);
      wr(8'h90, 8'h0c);
      waitr(8'h28, 16'hffff, 1'b0);
      rd(8'h42); chk(b, 8'h00);
      wr(8'h54, 8'h00);
      wr(8'h55, 8'h01);
      run[0] <= 1'b0;
      waitr(8'h42, 16'h0004, 1'b0);
      chk(monitorInterruptPin_n, 1'b1);
      wr(8'h80, 8'h0f);
      repeat (4) @(posedge clk);
      #1 chk(monitorInterruptPin_n, 1'b0);
      hp <= 16'h0028;
      run[0] <= 1'b1;
      waitr(8'h28, 16'h0100, 1'b1);
      // first fan reads good, second never does: only it keeps its hold
      @(posedge clk);
      spinupHold <= 3'b011;
      lo = 2'b00;
      for (int i = 0; i < 2100; i++) begin
         @(posedge clk);
         #1 lo = lo | ~fanDriveOutput[1:0];
      end
      chk(lo, 2'b01);
      @(posedge clk);
      spinupHold <= 3'b000;
      wr(8'h42, 8'h04);
      rd(8'h42); chk(b, 8'h00);
      chk(monitorInterruptPin_n, 1'b1);
      wr(8'ha0, 8'h40);
      run[0] <= 1'b0;
      lvl[0] <= 1'b1;
      waitr(8'h42, 16'h0004, 1'b0);
      wr(8'ha0, 8'h80);
      wr(8'h42, 8'h04);
      rd(8'h42); chk(b, 8'h00);
      tally_and_finish();
   end
endmodule // tb
